// file: pkg/spps_pkg.sv
// shared constants and state types for the phase sequence status block
package spps_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // control and status byte layout
  localparam int unsigned CTRL_W    = 8;   // width of the control and status byte
  localparam int unsigned START_BIT = 0;   // start, self clearing
  localparam int unsigned DONE_BIT  = 1;   // communication done, write 0 clears
  localparam int unsigned ERROR_BIT = 2;   // communication error, write 0 clears
  localparam int unsigned RSV3_BIT  = 3;   // reserved, reads zero
  localparam int unsigned PCNT_LSB  = 4;   // phase count field low bit
  localparam int unsigned PCNT_MSB  = 6;   // phase count field high bit
  localparam int unsigned RSV7_BIT  = 7;   // reserved, reads zero
  localparam int unsigned PCNT_W    = 3;   // phase count field width

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [2:0]  PCNT_RST  = 3'h0;
  localparam logic        DONE_RST  = 1'b0;
  localparam logic        ERROR_RST = 1'b0;
  localparam logic        START_RST = 1'b0;
  localparam logic        RSV_VAL   = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // link sizing
  localparam int unsigned BYTE_W     = 8;   // bits per serial byte
  localparam int unsigned BYTE_CNT_W = 12;  // per phase byte count width
  localparam logic [2:0]  LAST_BIT   = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // state machines
  typedef enum logic [2:0] {
    C_IDLE  = 3'b001,
    C_RUN   = 3'b010,
    C_DRAIN = 3'b100
  } spps_ctl_t;

  typedef enum logic [2:0] {
    L_IDLE  = 3'b001,
    L_SHIFT = 3'b010,
    L_END   = 3'b100
  } spps_lnk_t;

endpackage

// file: verilog/spps_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module spps_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         rst,
  // level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;     // first stage, read only by the second
  logic [W-1:0] sync_ff;     // second stage
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // next values
  always_comb begin
    nxt_meta = d;
    nxt_sync = meta_ff;
  end

  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q = sync_ff;

endmodule

// file: verilog/spps_shifter.sv
// msb first byte shift register on the link clock
`timescale 1ns/1ps
module spps_shifter
  import spps_pkg::*;
(
  // link clock and reset
  input  wire logic              link_clk,
  input  wire logic              rst,
  // control
  input  wire logic              load,
  input  wire logic [BYTE_W-1:0] load_byte,
  input  wire logic              sample,
  input  wire logic              miso_bit,
  // data
  output logic                   mosi,
  output logic      [BYTE_W-1:0] rx_byte
);

  logic [BYTE_W-1:0] sh_ff;    // shift register
  logic [BYTE_W-1:0] nxt_sh;

  ////////////////////////////////////////////////////////////////////////////////
  // load wins over shift; sampling moves the next bit to the output
  always_comb begin
    nxt_sh = sh_ff;
    if (load) begin
      nxt_sh = load_byte;
    end else if (sample) begin
      nxt_sh = {sh_ff[BYTE_W-2:0], miso_bit};
    end
  end

  // register
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      sh_ff <= '0;
    end else begin
      sh_ff <= nxt_sh;
    end
  end

  assign mosi    = sh_ff[BYTE_W-1];
  assign rx_byte = sh_ff;

endmodule

// file: verilog/spps_top.sv
// multi phase spi master: communication control, status flags and serial engine
// Overview of operation
// - three bit phase count gives one to eight phases
// - any failed phase sets error at communication end
// - error clears on write zero or start
// - done only after serial and dma finish
// - done clears on write zero or start
// - start write begins; start self clears at end
`timescale 1ns/1ps
module spps_top
  import spps_pkg::*;
#(
  parameter int unsigned BCW = BYTE_CNT_W   // per phase byte count width
) (
  // system clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // software control and status byte
  input  wire logic              ctrl_wr,
  input  wire logic [CTRL_W-1:0] ctrl_wdata,
  output logic      [CTRL_W-1:0] ctrl_rdata,
  output logic                   busy,
  // phase setup, held by software while idle
  input  wire logic [BCW-1:0]    phase_bytes,
  input  wire logic [BYTE_W-1:0] tx_fill,
  // received byte stream toward the dma engine
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output logic      [BYTE_W-1:0] rx_data,
  input  wire logic              dma_idle,
  // serial link
  input  wire logic              link_clk,
  output logic                   sck,
  output logic                   cs_n,
  output logic                   mosi,
  input  wire logic              miso
);

  ////////////////////////////////////////////////////////////////////////////////
  // system domain state
  spps_ctl_t           c_state_ff;      // control state
  spps_ctl_t           nxt_c_state;
  logic [PCNT_W-1:0]   pcnt_ff;         // phase count field
  logic [PCNT_W-1:0]   nxt_pcnt;
  logic                start_ff;        // start bit
  logic                nxt_start;
  logic                done_ff;         // communication done flag
  logic                nxt_done;
  logic                error_ff;        // communication error flag
  logic                nxt_error;
  logic                start_tog_ff;    // start event toward link
  logic                nxt_start_tog;
  logic [PCNT_W-1:0]   pcnt_snap_ff;    // phase count frozen for the link
  logic [PCNT_W-1:0]   nxt_pcnt_snap;
  logic [BCW-1:0]      bytes_snap_ff;   // byte count frozen for the link
  logic [BCW-1:0]      nxt_bytes_snap;
  logic [BYTE_W-1:0]   fill_snap_ff;    // transmit byte frozen for the link
  logic [BYTE_W-1:0]   nxt_fill_snap;
  logic                done_seen_ff;    // last seen link done toggle
  logic                nxt_done_seen;
  logic                req_seen_ff;     // last seen link byte toggle
  logic                nxt_req_seen;
  logic                ack_tog_ff;      // byte taken, back to link
  logic                nxt_ack_tog;
  logic                rx_valid_ff;     // byte waiting for dma
  logic                nxt_rx_valid;
  logic [BYTE_W-1:0]   rx_data_ff;      // byte handed to dma
  logic [BYTE_W-1:0]   nxt_rx_data;

  // crossings into the system domain
  logic                done_tog_s;      // link done toggle, synchronised
  logic                req_tog_s;       // link byte toggle, synchronised
  logic                link_err_s;      // link error level, synchronised
  logic                start_req;       // software asks for a start
  logic                done_evt;        // link reports serial end
  logic                req_evt;         // link offers a byte

  ////////////////////////////////////////////////////////////////////////////////
  // link domain state
  spps_lnk_t           l_state_ff;      // link state
  spps_lnk_t           nxt_l_state;
  logic                sck_ff;          // serial clock level
  logic                nxt_sck;
  logic                cs_n_ff;         // chip select, low while framing
  logic                nxt_cs_n;
  logic [2:0]          bit_ff;          // bit within byte
  logic [2:0]          nxt_bit;
  logic [BCW-1:0]      byte_ff;         // bytes left in phase, minus one
  logic [BCW-1:0]      nxt_byte;
  logic [PCNT_W-1:0]   ph_ff;           // phases left, minus one
  logic [PCNT_W-1:0]   nxt_ph;
  logic                err_ff;          // some phase of this communication failed
  logic                nxt_err;
  logic                done_tog_ff;     // serial end event toward system
  logic                nxt_done_tog;
  logic                req_tog_ff;      // byte event toward system
  logic                nxt_req_tog;
  logic [BYTE_W-1:0]   rx_hold_ff;      // byte held until acknowledged
  logic [BYTE_W-1:0]   nxt_rx_hold;
  logic                start_seen_ff;   // last seen start toggle
  logic                nxt_start_seen;

  // link domain helpers
  logic                start_tog_s;     // start toggle, synchronised
  logic                ack_tog_s;       // ack toggle, synchronised
  logic                miso_s;          // data in, synchronised
  logic                sh_load;         // reload transmit byte
  logic                sh_sample;       // take a bit in
  logic [BYTE_W-1:0]   sh_rx;           // assembled receive byte
  logic                rx_pending;      // previous byte not yet taken

  ////////////////////////////////////////////////////////////////////////////////
  // crossings
  spps_sync #(.W(3)) u_sync_sys (
    .clk (clk),
    .rst (rst),
    .d   ({done_tog_ff, req_tog_ff, err_ff}),
    .q   ({done_tog_s, req_tog_s, link_err_s})
  );

  spps_sync #(.W(3)) u_sync_link (
    .clk (link_clk),
    .rst (rst),
    .d   ({start_tog_ff, ack_tog_ff, miso}),
    .q   ({start_tog_s, ack_tog_s, miso_s})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // system domain events
  assign start_req = ctrl_wr & ctrl_wdata[START_BIT];
  assign done_evt  = done_tog_s ^ done_seen_ff;
  assign req_evt   = req_tog_s ^ req_seen_ff;

  // control, flags and byte hand-off, next values
  always_comb begin
    nxt_c_state    = c_state_ff;
    nxt_pcnt       = pcnt_ff;
    nxt_start      = start_ff;
    nxt_done       = done_ff;
    nxt_error      = error_ff;
    nxt_start_tog  = start_tog_ff;
    nxt_pcnt_snap  = pcnt_snap_ff;
    nxt_bytes_snap = bytes_snap_ff;
    nxt_fill_snap  = fill_snap_ff;
    nxt_done_seen  = done_tog_s;
    nxt_req_seen   = req_tog_s;
    nxt_ack_tog    = ack_tog_ff;
    nxt_rx_valid   = rx_valid_ff;
    nxt_rx_data    = rx_data_ff;
    // software write; reserved bits are not stored
    if (ctrl_wr) begin
      nxt_pcnt = ctrl_wdata[PCNT_MSB:PCNT_LSB];
      if (!ctrl_wdata[DONE_BIT]) begin
        nxt_done = 1'b0;
      end
      if (!ctrl_wdata[ERROR_BIT]) begin
        nxt_error = 1'b0;
      end
    end
    // byte from the link, then taken by dma
    if (req_evt) begin
      nxt_rx_valid = 1'b1;
      nxt_rx_data  = rx_hold_ff;
    end else if (rx_valid_ff && rx_ready) begin
      nxt_rx_valid = 1'b0;
      nxt_ack_tog  = ~ack_tog_ff;
    end
    case (c_state_ff)
      C_IDLE: begin
        // a start while idle launches and clears both flags
        if (start_req) begin
          nxt_start      = 1'b1;
          nxt_done       = 1'b0;
          nxt_error      = 1'b0;
          nxt_start_tog  = ~start_tog_ff;
          nxt_pcnt_snap  = ctrl_wdata[PCNT_MSB:PCNT_LSB];
          nxt_bytes_snap = phase_bytes;
          nxt_fill_snap  = tx_fill;
          nxt_c_state    = C_RUN;
        end
      end
      C_RUN: begin
        // serial side has finished all phases
        if (done_evt) begin
          nxt_c_state = C_DRAIN;
        end
      end
      C_DRAIN: begin
        // wait for the last byte and the dma engine to settle
        if (!rx_valid_ff && !req_evt && dma_idle) begin
          nxt_done    = 1'b1;
          nxt_error   = error_ff | link_err_s;
          nxt_start   = 1'b0;
          nxt_c_state = C_IDLE;
        end
      end
      default: begin
        nxt_c_state = C_IDLE;
      end
    endcase
  end

  // system domain registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_state_ff    <= C_IDLE;
      pcnt_ff       <= PCNT_RST;
      start_ff      <= START_RST;
      done_ff       <= DONE_RST;
      error_ff      <= ERROR_RST;
      start_tog_ff  <= 1'b0;
      pcnt_snap_ff  <= PCNT_RST;
      bytes_snap_ff <= '0;
      fill_snap_ff  <= '0;
      done_seen_ff  <= 1'b0;
      req_seen_ff   <= 1'b0;
      ack_tog_ff    <= 1'b0;
      rx_valid_ff   <= 1'b0;
      rx_data_ff    <= '0;
    end else begin
      c_state_ff    <= nxt_c_state;
      pcnt_ff       <= nxt_pcnt;
      start_ff      <= nxt_start;
      done_ff       <= nxt_done;
      error_ff      <= nxt_error;
      start_tog_ff  <= nxt_start_tog;
      pcnt_snap_ff  <= nxt_pcnt_snap;
      bytes_snap_ff <= nxt_bytes_snap;
      fill_snap_ff  <= nxt_fill_snap;
      done_seen_ff  <= nxt_done_seen;
      req_seen_ff   <= nxt_req_seen;
      ack_tog_ff    <= nxt_ack_tog;
      rx_valid_ff   <= nxt_rx_valid;
      rx_data_ff    <= nxt_rx_data;
    end
  end

  // status byte; reserved positions read zero
  assign ctrl_rdata = {RSV_VAL, pcnt_ff, RSV_VAL, error_ff, done_ff, start_ff};
  assign busy       = start_ff;
  assign rx_valid   = rx_valid_ff;
  assign rx_data    = rx_data_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: serial engine, one bit every two link clocks
  assign rx_pending = req_tog_ff ^ ack_tog_s;

  always_comb begin
    nxt_l_state    = l_state_ff;
    nxt_sck        = sck_ff;
    nxt_cs_n       = cs_n_ff;
    nxt_bit        = bit_ff;
    nxt_byte       = byte_ff;
    nxt_ph         = ph_ff;
    nxt_err        = err_ff;
    nxt_done_tog   = done_tog_ff;
    nxt_req_tog    = req_tog_ff;
    nxt_rx_hold    = rx_hold_ff;
    nxt_start_seen = start_tog_s;
    sh_load        = 1'b0;
    sh_sample      = 1'b0;
    case (l_state_ff)
      L_IDLE: begin
        if (!cs_n_ff) begin
          // one link clock of select lead-in, so the slave's first bit has
          // passed the miso synchroniser before the first sample
          nxt_bit     = 3'h0;
          nxt_byte    = bytes_snap_ff;
          nxt_ph      = pcnt_snap_ff;
          nxt_err     = 1'b0;
          sh_load     = 1'b1;
          nxt_l_state = L_SHIFT;
        end else if (start_tog_s ^ start_seen_ff) begin
          // frozen setup is stable once the start toggle is seen
          nxt_cs_n = 1'b0;
        end
      end
      L_SHIFT: begin
        if (!sck_ff) begin
          // rising edge: mosi stands still while the slave takes it
          nxt_sck = 1'b1;
        end else begin
          // falling edge: take the incoming bit and move the next one out
          nxt_sck = 1'b0;
          if (bit_ff == LAST_BIT) begin
            // byte complete; an untaken byte marks the phase failed
            nxt_bit = 3'h0;
            sh_load = 1'b1;
            if (rx_pending) begin
              nxt_err = 1'b1;
            end else begin
              nxt_rx_hold = {sh_rx[BYTE_W-2:0], miso_s};
              nxt_req_tog = ~req_tog_ff;
            end
            if (byte_ff != '0) begin
              nxt_byte = byte_ff - 1'b1;
            end else if (ph_ff != '0) begin
              nxt_ph   = ph_ff - 1'b1;
              nxt_byte = bytes_snap_ff;
            end else begin
              nxt_l_state = L_END;
            end
          end else begin
            sh_sample = 1'b1;
            nxt_bit   = bit_ff + 3'h1;
          end
        end
      end
      L_END: begin
        // release the slave and report serial end
        nxt_cs_n     = 1'b1;
        nxt_done_tog = ~done_tog_ff;
        nxt_l_state  = L_IDLE;
      end
      default: begin
        nxt_l_state = L_IDLE;
      end
    endcase
  end

  // link domain registers
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      l_state_ff    <= L_IDLE;
      sck_ff        <= 1'b0;
      cs_n_ff       <= 1'b1;
      bit_ff        <= 3'h0;
      byte_ff       <= '0;
      ph_ff         <= '0;
      err_ff        <= 1'b0;
      done_tog_ff   <= 1'b0;
      req_tog_ff    <= 1'b0;
      rx_hold_ff    <= '0;
      start_seen_ff <= 1'b0;
    end else begin
      l_state_ff    <= nxt_l_state;
      sck_ff        <= nxt_sck;
      cs_n_ff       <= nxt_cs_n;
      bit_ff        <= nxt_bit;
      byte_ff       <= nxt_byte;
      ph_ff         <= nxt_ph;
      err_ff        <= nxt_err;
      done_tog_ff   <= nxt_done_tog;
      req_tog_ff    <= nxt_req_tog;
      rx_hold_ff    <= nxt_rx_hold;
      start_seen_ff <= nxt_start_seen;
    end
  end

  // byte shifter
  spps_shifter u_shifter (
    .link_clk  (link_clk),
    .rst       (rst),
    .load      (sh_load),
    .load_byte (fill_snap_ff),
    .sample    (sh_sample),
    .miso_bit  (miso_s),
    .mosi      (mosi),
    .rx_byte   (sh_rx)
  );

  assign sck  = sck_ff;
  assign cs_n = cs_n_ff;

endmodule

// file: verification/spps_top_properties.sv
// concurrent checks on the ports of the phase sequence status block
`timescale 1ns/1ps
module spps_top_props
  import spps_pkg::*;
(
  // system domain
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ctrl_wr,
  input  wire logic [CTRL_W-1:0] ctrl_wdata,
  input  wire logic [CTRL_W-1:0] ctrl_rdata,
  input  wire logic              busy,
  input  wire logic              rx_valid,
  input  wire logic              dma_idle,
  // link domain
  input  wire logic              link_clk,
  input  wire logic              sck,
  input  wire logic              cs_n
);
  ////////////////////////////////////////////////////////////////////////////////
  // status byte and serial clock relations
  AST_RSV_ZERO: assert property (@(posedge clk) disable iff (rst)
    ctrl_rdata[7] == 1'b0 && ctrl_rdata[3] == 1'b0) else $error("reserved bit reads one");
  AST_PCNT_WRITE: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> ctrl_rdata[6:4] == $past(ctrl_wdata[6:4])) else $error("phase count not taken");
  AST_START_CLEARS: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr && ctrl_wdata[0] && !busy |=> busy && ctrl_rdata[2:1] == 2'b00)
    else $error("start did not launch with flags clear");
  AST_BUSY_IS_START: assert property (@(posedge clk) disable iff (rst)
    busy == ctrl_rdata[0]) else $error("busy differs from start bit");
  AST_W0_CLEAR: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr && !busy && !ctrl_wdata[0]
    |=> ctrl_rdata[2:1] == ($past(ctrl_rdata[2:1]) & $past(ctrl_wdata[2:1])))
    else $error("write zero clear wrong");
  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (rst)
    !ctrl_wr && !busy |=> $stable(ctrl_rdata)) else $error("status changed while idle");
  AST_DONE_CAUSE: assert property (@(posedge clk) disable iff (rst)
    $rose(ctrl_rdata[1]) |-> $fell(busy) && $past(dma_idle) && !$past(rx_valid))
    else $error("done set before transfers ended");
  AST_ERR_AT_END: assert property (@(posedge clk) disable iff (rst)
    $rose(ctrl_rdata[2]) |-> $rose(ctrl_rdata[1])) else $error("error set outside end");
  AST_END_DONE: assert property (@(posedge clk) disable iff (rst)
    $fell(busy) |-> ctrl_rdata[1]) else $error("start cleared without done");
  AST_SCK_IDLE: assert property (@(posedge link_clk) disable iff (rst)
    cs_n [*2] |-> !sck) else $error("serial clock moves outside frame");
  ////////////////////////////////////////////////////////////////////////////////
  // main scenarios reached
  COV_DONE: cover property (@(posedge clk) disable iff (rst) $rose(ctrl_rdata[1]));
  COV_ERR: cover property (@(posedge clk) disable iff (rst) $rose(ctrl_rdata[2]));
  COV_REFUSED: cover property (@(posedge clk) disable iff (rst) ctrl_wr && ctrl_wdata[0] && busy);
endmodule

bind spps_top spps_top_props u_props (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr),
  .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .busy(busy), .rx_valid(rx_valid),
  .dma_idle(dma_idle), .link_clk(link_clk), .sck(sck), .cs_n(cs_n));

// file: verification/spps_slave_model.sv
// serial slave model: answers all ones, gathers the bytes the master sends
`timescale 1ns/1ps
module spps_slave_model (
  // serial link
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  // capture for the bench
  output logic [7:0]       last_byte,
  output logic [15:0]      bit_cnt
);
  logic [7:0] shreg;  // bits gathered msb first
  initial begin
    miso = 1'b0;
    last_byte = 8'h00;
    bit_cnt = 16'h0000;
    shreg = 8'h00;
  end
  // frame start: drive data early, master synchronises it
  always @(negedge cs_n) begin
    bit_cnt = 16'h0000;
    miso = 1'b1;
  end
  // master samples falling and holds mosi still at rising, so capture mosi there
  always @(posedge sck) begin
    if (!cs_n) begin
      shreg = {shreg[6:0], mosi};
      bit_cnt = bit_cnt + 16'h0001;
      if (bit_cnt[2:0] == 3'h0) begin
        last_byte = shreg;
      end
    end
  end
  // after the hold time the released line shows the inverse, not the last value
  always @(posedge cs_n) begin
    #64;
    if (cs_n) begin
      miso = ~miso;
    end
  end
endmodule

// file: verification/spps_top_tb.sv
// self checking bench for the phase sequence status block
`timescale 1ns/1ps
module spps_top_tb
  import spps_pkg::*;
;
  logic              clk, rst, link_clk;          // clocks and reset
  logic              ctrl_wr, busy;               // control strobe, busy
  logic [CTRL_W-1:0] ctrl_wdata, ctrl_rdata;      // control byte
  logic [11:0]       phase_bytes;                 // bytes per phase minus one
  logic [BYTE_W-1:0] tx_fill, rx_data, got_byte;  // data bytes
  logic              rx_valid, rx_ready, dma_idle; // dma side
  logic              sck, cs_n, mosi, miso;       // serial link
  logic [15:0]       got_bits;                    // bits seen by the slave
  logic              wr_d, busy_d;                // monitor history
  logic [7:0]        exp_q[$];                    // expected results in order
  int                miscompares, cmp_count;

  spps_top dut (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .ctrl_rdata(ctrl_rdata), .busy(busy), .phase_bytes(phase_bytes), .tx_fill(tx_fill),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .dma_idle(dma_idle),
    .link_clk(link_clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  spps_slave_model slave (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .last_byte(got_byte), .bit_cnt(got_bits));

  ////////////////////////////////////////////////////////////////////////////////
  // clocks, link clock unrelated in phase
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #16 link_clk = ~link_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare, verdict and queue helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] pop();
    if (exp_q.size() == 0) begin
      return 16'hxxxx;
    end
    return 16'(exp_q.pop_front());
  endfunction
  // one write pulse, launched just after an edge
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    #1;
    ctrl_wr = 1'b1;
    ctrl_wdata = d;
    @(posedge clk);
    #1;
    ctrl_wr = 1'b0;
  endtask
  // bounded wait on busy or chip select
  task automatic wait_for(input bit on_busy, input logic v);
    for (int i = 0; i < 40000; i++) begin
      if ((on_busy ? busy : cs_n) === v) begin
        return;
      end
      @(posedge clk);
      #1;
    end
    miscompares++;
    $display("wait limit reached");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: each visible result takes the oldest note (pre-edge values)
  always @(posedge clk) begin
    if (wr_d) begin
      chk("status after write", 16'(ctrl_rdata), pop());
    end
    if (busy_d && !busy) begin
      chk("status at end", 16'(ctrl_rdata), pop());
    end
    if (rx_valid && rx_ready) begin
      chk("received byte", 16'(rx_data), pop());
    end
    wr_d <= ctrl_wr && !rst;
    busy_d <= busy;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one communication; mode 0 plain, 1 receive overrun, 2 slow dma
  task automatic run(input logic [2:0] pc, input logic [11:0] pb, input int mode);
    int n;
    n = (int'(pc) + 1) * (int'(pb) + 1);
    phase_bytes = pb;
    tx_fill = 8'($urandom);
    rx_ready = (mode != 1);
    dma_idle = (mode != 2);
    exp_q.push_back({1'b0, pc, 4'h1});
    exp_q.push_back({1'b0, pc, 4'h1});
    repeat ((mode == 1) ? 1 : n) exp_q.push_back(8'hff);
    exp_q.push_back({1'b0, pc, 1'b0, mode == 1, 2'b10});
    wr({1'b1, pc, 4'h9});
    wr({1'b0, pc, 4'h1});
    wait_for(1'b0, 1'b0);
    wait_for(1'b0, 1'b1);
    rx_ready = 1'b1;
    if (mode == 2) begin
      repeat (40) @(posedge clk);
      #1;
      chk("done waits for dma", 16'({busy, ctrl_rdata[1]}), 16'h0002);
      dma_idle = 1'b1;
    end
    wait_for(1'b1, 1'b0);
    chk("bits sent", got_bits, 16'(8 * n));
    chk("byte sent", 16'(got_byte), 16'(tx_fill));
    $display("test communication pc %0d mode %0d done", pc, mode);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    miscompares = 0;
    cmp_count = 0;
    rst = 1'b1;
    ctrl_wr = 1'b0;
    ctrl_wdata = 8'h00;
    phase_bytes = 12'h000;
    tx_fill = 8'h00;
    rx_ready = 1'b1;
    dma_idle = 1'b1;
    void'($urandom(74120));
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("reset status", 16'(ctrl_rdata), 16'h0000);
    chk("reset link", 16'({busy, cs_n, sck}), 16'h0002);
    $display("test reset done");
    for (int p = 0; p < 8; p++) begin
      run(3'(p), 12'($urandom_range(2, 0)), (p == 3) ? 2 : 0);
    end
    run(3'h0, 12'h001, 1);
    exp_q.push_back(8'h72);
    wr(8'hfa);
    exp_q.push_back(8'h00);
    wr(8'h08);
    run(3'h0, 12'h001, 1);
    run(3'h2, 12'h000, 0);
    $display("test flag clearing done");
    repeat (5) @(posedge clk);
    chk("notes left", 16'(exp_q.size()), 16'h0000);
    final_report();
  end

  // watchdog, well beyond the expected run length
  initial begin
    #600000;
    miscompares++;
    $display("watchdog expired");
    final_report();
  end
endmodule
